// ===== logic/modem_irq_status_regs.vh
// register offsets, field positions and reset values of the modem event and status bank
// Contract
// R1: read-only byte at 0x10 holds buffer start address of last received packet
// R2: per-flag read-write mask bit, same position; one suppresses interrupt; resets zero
// R3: flag bits: 7 timeout,6 rx done,5 crc error,4 header,3 tx,2 scan,1 hop,0 found
// R4: host write to flag register clears pending flags; host writes to acknowledge
// R5: all event flags are zero after reset
// R6: read-only byte at 0x13 holds payload byte count of latest packet
// R7: 16-bit valid header count, high byte 0x14 and low byte 0x15
// R8: 16-bit valid packet count, high byte 0x16 and low byte 0x17
// R9: both counters are held at zero while the modem is in sleep
// R10: status byte: code rate, clear (resets one), header valid, rx on, sync, detect
// R11: snr byte is two's complement snr in decibels times four
// R12: flags set on modem events; interrupt while any unmasked flag is set
// R13: start address, length and snr update together on each completed reception
`ifndef MODEM_IRQ_STATUS_REGS_VH
`define MODEM_IRQ_STATUS_REGS_VH

// register offsets
`define RX_LAST_PACKET_START_ADDR 8'h10
`define EVENT_MASK_ADDR           8'h11
`define EVENT_FLAGS_ADDR          8'h12
`define RX_PAYLOAD_LENGTH_ADDR    8'h13
`define HEADER_COUNT_HIGH_ADDR    8'h14
`define HEADER_COUNT_LOW_ADDR     8'h15
`define PACKET_COUNT_HIGH_ADDR    8'h16
`define PACKET_COUNT_LOW_ADDR     8'h17
`define MODEM_STATE_ADDR          8'h18
`define PACKET_SNR_ADDR           8'h19

// event flag and mask bit positions
`define RECEIVE_TIMEOUT_BIT       7
`define RECEPTION_COMPLETE_BIT    6
`define PAYLOAD_CHECK_FAIL_BIT    5
`define HEADER_OK_BIT             4
`define TRANSMIT_COMPLETE_BIT     3
`define ACTIVITY_SCAN_DONE_BIT    2
`define HOP_CHANGE_BIT            1
`define ACTIVITY_FOUND_BIT        0

// modem state field positions
`define CODE_RATE_MSB             7
`define CODE_RATE_LSB             5
`define MODEM_CLEAR_BIT           4
`define HEADER_INFO_VALID_BIT     3
`define RX_ONGOING_BIT            2
`define SIGNAL_SYNC_BIT           1
`define SIGNAL_DETECT_BIT         0

// reset values
`define EVENT_MASK_RESET          8'h00
`define EVENT_FLAGS_RESET         8'h00
`define MODEM_STATE_RESET         8'h10
`define RX_INFO_RESET             8'h00
`define COUNT_RESET               16'h0000
`define COUNT_STEP                16'h0001
`define UNMAPPED_READ             8'h00

`endif

// ===== logic/modem_irq_status_regs.v
// event mask, event flag and receive status register bank of the spread-spectrum modem
`timescale 1ns/100ps
`include "modem_irq_status_regs.vh"

module modem_irq_status_regs #(
    parameter DATA_W  = 8,
    parameter ADDR_W  = 8,
    parameter COUNT_W = 16
) (
    input  wire                sys_clk,
    input  wire                rst,
    // host register port
    input  wire [ADDR_W-1:0]   reg_addr,
    input  wire [DATA_W-1:0]   reg_wdata,
    input  wire                reg_wr,
    input  wire                reg_rd,
    output reg  [DATA_W-1:0]   reg_rdata,
    output reg                 reg_rvalid,
    // modem event pulses, one bit per flag position
    input  wire [DATA_W-1:0]   modem_event,
    // counter sources and modem mode
    input  wire                valid_packet_pulse,
    input  wire                sleep_mode,
    input  wire                rx_mode_entry,
    // completed reception data
    input  wire                rx_info_update,
    input  wire [DATA_W-1:0]   rx_start_addr_in,
    input  wire [DATA_W-1:0]   rx_length_in,
    input  wire [DATA_W-1:0]   rx_snr_in,
    // live modem status
    input  wire [2:0]          code_rate_in,
    input  wire                modem_clear_in,
    input  wire                header_info_valid_in,
    input  wire                rx_ongoing_in,
    input  wire                signal_sync_in,
    input  wire                signal_detect_in,
    // interrupt to host
    output reg                 host_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // storage

    reg  [DATA_W-1:0]  event_mask_q;
    reg  [DATA_W-1:0]  event_mask_d;
    reg  [DATA_W-1:0]  event_flags_q;
    wire [DATA_W-1:0]  event_flags_d;
    reg  [DATA_W-1:0]  rx_last_packet_start_q;
    reg  [DATA_W-1:0]  rx_payload_length_q;
    reg  [DATA_W-1:0]  packet_snr_quarter_db_q;
    reg  [COUNT_W-1:0] header_count_q;
    reg  [COUNT_W-1:0] header_count_d;
    reg  [COUNT_W-1:0] packet_count_q;
    reg  [COUNT_W-1:0] packet_count_d;
    reg  [DATA_W-1:0]  modem_state_bits_q;
    reg  [DATA_W-1:0]  modem_state_bits_d;
    reg  [DATA_W-1:0]  read_data_d;
    wire [DATA_W-1:0]  flag_clear;
    wire               irq_d;

    ////////////////////////////////////////////////////////////////////////////////
    // strobe decoding used by the write path; the read path decodes with its own case

    // true when a strobe targets the given offset
    function hit;
        input [ADDR_W-1:0] addr;
        input [ADDR_W-1:0] target;
        input              strobe;
        begin
            hit = strobe && (addr == target);
        end
    endfunction

    // host clear pattern: every bit written as one is cleared
    assign flag_clear = hit(reg_addr, `EVENT_FLAGS_ADDR, reg_wr) ? reg_wdata
                                                                  : {DATA_W{1'b0}};

    ////////////////////////////////////////////////////////////////////////////////
    // event mask register

    // mask follows host writes, other offsets leave it alone
    always @* begin
        event_mask_d = event_mask_q;
        if (hit(reg_addr, `EVENT_MASK_ADDR, reg_wr)) begin
            event_mask_d = reg_wdata; // [R2]
        end
    end

    // mask storage with zero reset
    always @(posedge sys_clk) begin
        if (rst) begin
            event_mask_q <= `EVENT_MASK_RESET; // [R2]
        end else begin
            event_mask_q <= event_mask_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // event flags, one sticky bit per event position

    genvar i;
    generate
        for (i = 0; i < DATA_W; i = i + 1) begin : g_flag
            // a new event in the clear cycle survives the clear
            assign event_flags_d[i] = modem_event[i] |
                                      (event_flags_q[i] & ~flag_clear[i]); // [R12] [R4] [R3]
        end
    endgenerate

    // flag storage, nothing pending after reset
    always @(posedge sys_clk) begin
        if (rst) begin
            event_flags_q <= `EVENT_FLAGS_RESET; // [R5]
        end else begin
            event_flags_q <= event_flags_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt output

    // unmasked pending flags drive the interrupt, using next values to avoid lag
    assign irq_d = |(event_flags_d & ~event_mask_d); // [R12] [R2]

    // registered interrupt line
    always @(posedge sys_clk) begin
        if (rst) begin
            host_irq <= 1'b0;
        end else begin
            host_irq <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // last reception information

    // start address, length and snr are captured as one set
    always @(posedge sys_clk) begin
        if (rst) begin
            rx_last_packet_start_q  <= `RX_INFO_RESET;
            rx_payload_length_q     <= `RX_INFO_RESET;
            packet_snr_quarter_db_q <= `RX_INFO_RESET;
        end else if (rx_info_update) begin
            rx_last_packet_start_q  <= rx_start_addr_in; // [R13] [R1]
            rx_payload_length_q     <= rx_length_in;     // [R13] [R6]
            packet_snr_quarter_db_q <= rx_snr_in;        // [R13] [R11]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // valid header and valid packet counters

    // sleep holds both at zero; entering receive restarts them; otherwise count
    always @* begin
        header_count_d = header_count_q;
        packet_count_d = packet_count_q;
        if (sleep_mode) begin
            header_count_d = `COUNT_RESET; // [R9]
            packet_count_d = `COUNT_RESET; // [R9]
        end else if (rx_mode_entry) begin
            header_count_d = `COUNT_RESET;
            packet_count_d = `COUNT_RESET;
        end else begin
            if (modem_event[`HEADER_OK_BIT]) begin
                header_count_d = header_count_q + `COUNT_STEP; // [R7]
            end
            if (valid_packet_pulse) begin
                packet_count_d = packet_count_q + `COUNT_STEP; // [R8]
            end
        end
    end

    // counter storage
    always @(posedge sys_clk) begin
        if (rst) begin
            header_count_q <= `COUNT_RESET;
            packet_count_q <= `COUNT_RESET;
        end else begin
            header_count_q <= header_count_d;
            packet_count_q <= packet_count_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // modem status register

    // live status gathered into its fields every cycle
    always @* begin
        modem_state_bits_d = `MODEM_STATE_RESET;
        modem_state_bits_d[`CODE_RATE_MSB:`CODE_RATE_LSB] = code_rate_in; // [R10]
        modem_state_bits_d[`MODEM_CLEAR_BIT]       = modem_clear_in;       // [R10]
        modem_state_bits_d[`HEADER_INFO_VALID_BIT] = header_info_valid_in; // [R10]
        modem_state_bits_d[`RX_ONGOING_BIT]        = rx_ongoing_in;        // [R10]
        modem_state_bits_d[`SIGNAL_SYNC_BIT]       = signal_sync_in;       // [R10]
        modem_state_bits_d[`SIGNAL_DETECT_BIT]     = signal_detect_in;     // [R10]
    end

    // status storage, modem clear reads one after reset
    always @(posedge sys_clk) begin
        if (rst) begin
            modem_state_bits_q <= `MODEM_STATE_RESET; // [R10]
        end else begin
            modem_state_bits_q <= modem_state_bits_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path

    // read multiplexer, unmapped offsets answer zero
    always @* begin
        case (reg_addr)
            `RX_LAST_PACKET_START_ADDR: begin
                read_data_d = rx_last_packet_start_q; // [R1]
            end
            `EVENT_MASK_ADDR: begin
                read_data_d = event_mask_q;
            end
            `EVENT_FLAGS_ADDR: begin
                read_data_d = event_flags_q; // [R3]
            end
            `RX_PAYLOAD_LENGTH_ADDR: begin
                read_data_d = rx_payload_length_q; // [R6]
            end
            `HEADER_COUNT_HIGH_ADDR: begin
                read_data_d = header_count_q[COUNT_W-1:DATA_W]; // [R7]
            end
            `HEADER_COUNT_LOW_ADDR: begin
                read_data_d = header_count_q[DATA_W-1:0]; // [R7]
            end
            `PACKET_COUNT_HIGH_ADDR: begin
                read_data_d = packet_count_q[COUNT_W-1:DATA_W]; // [R8]
            end
            `PACKET_COUNT_LOW_ADDR: begin
                read_data_d = packet_count_q[DATA_W-1:0]; // [R8]
            end
            `MODEM_STATE_ADDR: begin
                read_data_d = modem_state_bits_q; // [R10]
            end
            `PACKET_SNR_ADDR: begin
                read_data_d = packet_snr_quarter_db_q; // [R11]
            end
            default: begin
                read_data_d = `UNMAPPED_READ;
            end
        endcase
    end

    // registered read answer, valid one cycle after the strobe
    always @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata  <= `UNMAPPED_READ;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= read_data_d;
            end
        end
    end

endmodule

// ===== tb/modem_irq_status_regs_props.sv
// concurrent checks on the ports of the modem event and status register bank
`timescale 1ns/100ps
module modem_irq_status_regs_chk (
    input wire       sys_clk,
    input wire       rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       reg_rvalid,
    input wire [7:0] modem_event,
    input wire       sleep_mode,
    input wire       rx_info_update,
    input wire [7:0] rx_length_in,
    input wire [2:0] code_rate_in,
    input wire       modem_clear_in,
    input wire       header_info_valid_in,
    input wire       rx_ongoing_in,
    input wire       signal_sync_in,
    input wire       signal_detect_in,
    input wire       host_irq
);
    reg  [7:0] mask_q;
    wire [7:0] stat_w;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // live status inputs packed as the status byte
    assign stat_w = {code_rate_in, modem_clear_in, header_info_valid_in, rx_ongoing_in,
                     signal_sync_in, signal_detect_in};
    // shadow of the mask register
    always @(posedge sys_clk) begin
        if (rst)
            mask_q <= 8'h00;
        else if (reg_wr && reg_addr == 8'h11)
            mask_q <= reg_wdata;
    end
    rd_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    no_spurious_a: assert property (!reg_rd |=> !reg_rvalid)
        else $error("read valid without request");
    unmapped_zero_a: assert property (reg_rd && (reg_addr < 8'h10 || reg_addr > 8'h19)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    mask_read_a: assert property (reg_rd && !reg_wr && reg_addr == 8'h11
        |=> reg_rdata == mask_q) else $error("mask readback wrong");
    mask_all_a: assert property (reg_wr && reg_addr == 8'h11 && reg_wdata == 8'hff
        |=> !host_irq) else $error("full mask leaves interrupt");
    event_irq_a: assert property (!reg_wr && (modem_event & ~mask_q) != 8'h00
        |=> host_irq) else $error("unmasked event without interrupt");
    clear_irq_a: assert property (reg_wr && reg_addr == 8'h12 && reg_wdata == 8'hff
        && modem_event == 8'h00 |=> !host_irq) else $error("clear leaves interrupt");
    sleep_zero_a: assert property ($past(sleep_mode) && sleep_mode && reg_rd
        && reg_addr[7:2] == 6'h05 |=> reg_rdata == 8'h00) else $error("count in sleep");
    status_byte_a: assert property (reg_rd && reg_addr == 8'h18 && !$past(rst)
        |=> reg_rdata == $past(stat_w, 2)) else $error("status byte wrong");
    rx_len_a: assert property (rx_info_update ##2 (reg_rd && reg_addr == 8'h13)
        |=> reg_rdata == $past(rx_length_in, 3)) else $error("length not captured");
    cover property (host_irq);
    cover property (sleep_mode && reg_rd);
    cover property (reg_wr && reg_addr == 8'h12);
endmodule
bind modem_irq_status_regs modem_irq_status_regs_chk u_chk (.*);

// ===== tb/host_port_model.sv
// host side of the register port: single strobed reads and writes
`timescale 1ns/100ps
module host_port_model (
    input  wire       sys_clk,
    input  wire [7:0] reg_rdata,
    input  wire       reg_rvalid,
    output reg  [7:0] reg_addr,
    output reg  [7:0] reg_wdata,
    output reg        reg_wr,
    output reg        reg_rd
);
    // idle port at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one write strobe; a write to the flag register acknowledges events
    task wr(input [7:0] a, input [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // one read strobe; data stands the cycle after the strobe
    task rd(input [7:0] a, output [7:0] d, output ok);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        ok = reg_rvalid;
        d = reg_rdata;
    endtask
endmodule

// ===== tb/modem_irq_status_regs_test.sv
// self-checking bench for the modem event and status register bank
`timescale 1ns/100ps
module modem_irq_status_regs_test;
    reg        sys_clk = 1'b0;
    reg        rst = 1'b1;
    reg  [7:0] modem_event = 8'h00;
    reg        valid_packet_pulse = 1'b0;
    reg        sleep_mode = 1'b0;
    reg        rx_mode_entry = 1'b0;
    reg        rx_info_update = 1'b0;
    reg  [7:0] rx_start_addr_in = 8'h00;
    reg  [7:0] rx_length_in = 8'h00;
    reg  [7:0] rx_snr_in = 8'h00;
    reg  [7:0] stat = 8'h10;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire       reg_wr, reg_rd, reg_rvalid, host_irq;
    integer    fail_count = 0;
    integer    n_compared = 0;
    integer    i;
    always #5 sys_clk = ~sys_clk;
    modem_irq_status_regs u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .modem_event(modem_event),
        .valid_packet_pulse(valid_packet_pulse), .sleep_mode(sleep_mode),
        .rx_mode_entry(rx_mode_entry), .rx_info_update(rx_info_update),
        .rx_start_addr_in(rx_start_addr_in), .rx_length_in(rx_length_in),
        .rx_snr_in(rx_snr_in), .code_rate_in(stat[7:5]), .modem_clear_in(stat[4]),
        .header_info_valid_in(stat[3]), .rx_ongoing_in(stat[2]),
        .signal_sync_in(stat[1]), .signal_detect_in(stat[0]), .host_irq(host_irq));
    host_port_model host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    ////////////////////////////////////////////////////////////////////////////
    // compare and count
    task chk(input string name, input [7:0] seen, input [7:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // read a register, a missing answer counts as a mismatch
    task rdc(input [7:0] a, input [7:0] exp);
        reg [7:0] d;
        reg       ok;
        host.rd(a, d, ok);
        chk($sformatf("reg %h", a), (ok === 1'b1) ? d : ~exp, exp);
    endtask
    // one-cycle event and packet pulse
    task ev(input [7:0] v, input p);
        @(negedge sys_clk);
        modem_event = v;
        valid_packet_pulse = p;
        @(negedge sys_clk);
        modem_event = 8'h00;
        valid_packet_pulse = 1'b0;
    endtask
    task irq(input b);
        chk("host_irq", {7'h00, host_irq}, {7'h00, b});
    endtask
    task conclude;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        irq(1'b0);
        rdc(8'h11, 8'h00);
        rdc(8'h12, 8'h00);
        rdc(8'h18, 8'h10);
        rdc(8'h20, 8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            host.wr(8'h11, 8'h01 << i);
            ev(8'h01 << i, 1'b0);
            irq(1'b0);
            rdc(8'h12, 8'h01 << i);
            rdc(8'h11, 8'h01 << i);
            host.wr(8'h11, 8'h00);
            irq(1'b1);
            host.wr(8'h12, 8'h01 << i);
            irq(1'b0);
            rdc(8'h12, 8'h00);
        end
        ev(8'hff, 1'b0);
        host.wr(8'h11, 8'hff);
        irq(1'b0);
        host.wr(8'h11, 8'h00);
        irq(1'b1);
        host.wr(8'h12, 8'hff);
        irq(1'b0);
        // completed reception capture, inputs moved afterwards
        @(negedge sys_clk);
        rx_start_addr_in = 8'h40;
        rx_length_in = 8'h1f;
        rx_snr_in = 8'hf6; // minus 2.5 dB in quarter steps
        rx_info_update = 1'b1;
        @(negedge sys_clk);
        rx_info_update = 1'b0;
        rx_start_addr_in = 8'h00;
        rx_length_in = 8'h00;
        rx_snr_in = 8'h00;
        rdc(8'h13, 8'h1f);
        rdc(8'h10, 8'h40);
        rdc(8'h19, 8'hf6);
        // counters restart on receive entry, then three headers and two packets
        @(negedge sys_clk);
        rx_mode_entry = 1'b1;
        @(negedge sys_clk);
        rx_mode_entry = 1'b0;
        for (i = 0; i < 3; i = i + 1)
            ev(8'h10, i < 2);
        rdc(8'h14, 8'h00);
        rdc(8'h15, 8'h03);
        rdc(8'h16, 8'h00);
        rdc(8'h17, 8'h02);
        sleep_mode = 1'b1;
        for (i = 8'h14; i < 8'h18; i = i + 1)
            rdc(i[7:0], 8'h00);
        sleep_mode = 1'b0;
        stat = 8'haa;
        rdc(8'h18, 8'haa);
        stat = 8'h55;
        rdc(8'h18, 8'h55);
        // event and clear of the same flag in one cycle: the new event survives
        fork
            host.wr(8'h12, 8'h40);
            ev(8'h40, 1'b0);
        join
        rdc(8'h12, 8'h50);
        irq(1'b1);
        conclude;
    end
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #20000;
        fail_count = fail_count + 1;
        conclude;
    end
endmodule
